// ==== bench/csb_fetch_model.sv ====
// far side: register read ports and program word lengths
`timescale 1ns/10ps
module csb_fetch_model (
  input wire logic [9:0] pc,
  input wire logic reg_sel,
  output logic [7:0] gp_reg_value,
  output logic [7:0] io_reg_value,
  output logic next_is_two_word
);
  // two selectable registers of each kind
  assign gp_reg_value = reg_sel ? 8'h40 : 8'h01;
  assign io_reg_value = reg_sel ? 8'hbf : 8'h80;
  // a two-word instruction follows every odd address
  assign next_is_two_word = pc[0];
endmodule : csb_fetch_model

// ==== bench/csb_unit_checker.sv ====
// port assertions for the compare, skip and branch unit
`timescale 1ns/10ps
module csb_unit_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire csb_pkg::csb_op_t instr_op,
  input wire logic [2:0] bit_index,
  input wire logic [6:0] branch_offset,
  input wire logic [7:0] constant_value,
  input wire logic [7:0] gp_reg_value,
  input wire logic [7:0] io_reg_value,
  input wire logic next_is_two_word,
  input wire logic flags_load,
  input wire logic instr_ready,
  input wire logic [csb_pkg::PC_W-1:0] pc,
  input wire logic [7:0] core_status_flags,
  input wire logic retire
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // accepted request, branch target and fall-through address
  wire acc = instr_valid & instr_ready;
  wire cmp = acc && instr_op == csb_pkg::CSB_COMPARE_WITH_CONSTANT;
  wire lt = core_status_flags[2] ^ core_status_flags[3];
  wire logic [9:0] tgt = pc + {{3{branch_offset[6]}}, branch_offset} + 10'h001;
  wire logic [9:0] nxt = pc + 10'h001;
  chk_cmp_retire: assert property (cmp |=> retire)
    else $error("compare did not retire");
  chk_cmp_flags: assert property (cmp |=> core_status_flags[1:0] ==
    {$past(gp_reg_value) == $past(constant_value), $past(gp_reg_value) < $past(constant_value)})
    else $error("compare flags wrong");
  chk_eq_taken: assert property (acc && instr_op == csb_pkg::CSB_BRANCH_IF_EQUAL
    && core_status_flags[1] |=> pc == $past(tgt) && !instr_ready ##1 instr_ready)
    else $error("taken branch target or stall wrong");
  chk_ne_fall: assert property (acc && instr_op == csb_pkg::CSB_BRANCH_IF_NOT_EQUAL
    && core_status_flags[1] |=> pc == $past(nxt) && instr_ready)
    else $error("untaken branch wrong");
  chk_flags_kept: assert property (acc && !cmp && !flags_load |=> $stable(core_status_flags))
    else $error("flags changed by skip or branch");
  chk_skip_long: assert property (acc && instr_op == csb_pkg::CSB_SKIP_IF_REG_BIT_SET
    && gp_reg_value[bit_index] && next_is_two_word
    |=> pc == $past(pc) + 10'h003 && !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("long skip wrong");
  chk_io_skip: assert property (acc && instr_op == csb_pkg::CSB_SKIP_IF_IO_BIT_CLEAR
    && !io_reg_value[bit_index] && !next_is_two_word |=> pc == $past(pc) + 10'h002)
    else $error("short io skip wrong");
  chk_signed_lt: assert property (acc && instr_op == csb_pkg::CSB_BRANCH_IF_SIGNED_LT
    |=> pc == ($past(lt) ? $past(tgt) : $past(nxt)))
    else $error("signed less-than branch wrong");
endmodule : csb_unit_checker
bind csb_unit csb_unit_checker u_chk (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
  .instr_op(instr_op), .bit_index(bit_index), .branch_offset(branch_offset),
  .constant_value(constant_value), .gp_reg_value(gp_reg_value), .io_reg_value(io_reg_value),
  .next_is_two_word(next_is_two_word), .flags_load(flags_load), .instr_ready(instr_ready),
  .pc(pc), .core_status_flags(core_status_flags), .retire(retire));

// ==== bench/csb_unit_tb.sv ====
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/10ps
module csb_unit_tb;
  logic clk_sys, rst, instr_valid, two_word, flags_load, instr_ready, retire, reg_sel;
  csb_pkg::csb_op_t instr_op;
  logic [2:0] bit_index;
  logic [6:0] branch_offset;
  logic [7:0] constant_value, gp_val, io_val, flags_in, flags;
  logic [9:0] pc, exp_pc;
  int mismatches = 0;
  int compares = 0;
  csb_unit u_dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .bit_index(bit_index), .branch_offset(branch_offset), .constant_value(constant_value),
    .gp_reg_value(gp_val), .io_reg_value(io_val), .next_is_two_word(two_word),
    .flags_load(flags_load), .flags_in(flags_in), .instr_ready(instr_ready), .pc(pc),
    .core_status_flags(flags), .retire(retire));
  csb_fetch_model u_far (.pc(pc), .reg_sel(reg_sel), .gp_reg_value(gp_val),
    .io_reg_value(io_val), .next_is_two_word(two_word));
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  // offer one instruction once idle, then check where the counter went
  task automatic issue(input csb_pkg::csb_op_t op, input int b, input logic [6:0] k,
      input logic [9:0] nxt);
    int n = 0;
    int m = 1;
    int cyc = 1;
    while (instr_ready !== 1'h1 && n < 8) begin
      @(negedge clk_sys);
      n++;
    end
    if (instr_ready !== 1'h1) begin
      mismatches++;
      test_done();
    end
    @(posedge clk_sys);
    instr_valid <= 1'h1;
    instr_op <= op;
    bit_index <= 3'(b);
    branch_offset <= k;
    @(posedge clk_sys);
    instr_valid <= 1'h0;
    @(negedge clk_sys);
    chk(16'(pc), 16'(nxt));
    // a skip costs one cycle per word moved, a taken branch two
    if (nxt != exp_pc + 10'h001) begin
      cyc = (op <= csb_pkg::CSB_SKIP_IF_IO_BIT_SET) ? int'(nxt - exp_pc) : 2;
    end
    chk(16'(instr_ready), 16'(cyc == 1));
    while (retire !== 1'h1 && m < 4) begin
      @(negedge clk_sys);
      m++;
    end
    chk(16'(m), 16'(cyc));
    exp_pc = nxt;
  endtask : issue
  // branch decision per op: watched flag (8 is n xor v) and polarity
  function automatic logic taken(input int i, input logic [7:0] f, input int b);
    int idx [13] = '{0, 0, 1, 1, 0, 0, 0, 0, 2, 2, 8, 8, 5};
    logic [12:0] pol = 13'h1995;
    logic [8:0] e = {f[2] ^ f[3], f};
    if (i < 2) e[0] = f[b];
    return e[idx[i]] == pol[i];
  endfunction : taken
  // every conditional branch under three flag patterns, offset sign alternating from one op to the next
  task automatic t_branches();
    logic [7:0] pats [3] = '{8'h00, 8'h15, 8'h2a};
    logic [6:0] k;
    for (int p = 0; p < 3; p++) begin
      @(posedge clk_sys);
      flags_load <= 1'h1;
      flags_in <= pats[p];
      @(posedge clk_sys);
      flags_load <= 1'h0;
      for (int i = 0; i < 13; i++) begin
        k = i[0] ? 7'h7c : 7'h09;
        issue(csb_pkg::csb_op_t'(i + 6), i % 8, k, taken(i, pats[p], i % 8) ? exp_pc +
          {{3{k[6]}}, k} + 10'h001 : exp_pc + 10'h001);
        chk(16'(flags), 16'(pats[p]));
      end
    end
    $display("branch test done");
  endtask : t_branches
  // all four skips, bit true and false, over one- and two-word followers
  task automatic t_skips();
    logic hit;
    for (int i = 0; i < 16; i++) begin
      if (exp_pc[0] != i[3]) issue(csb_pkg::CSB_NOP, 0, 7'h00, exp_pc + 10'h001);
      hit = ((i[1] == i[2]) == i[0]);
      issue(csb_pkg::csb_op_t'(2 + i % 4), i[2] ? 7 : 0, 7'h00,
        exp_pc + (hit ? (exp_pc[0] ? 10'h003 : 10'h002) : 10'h001));
    end
    $display("skip test done");
  endtask : t_skips
  // compare equal, then one below the constant
  task automatic t_compare();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      reg_sel <= 1'h1;
      constant_value <= 8'h40 + 8'(i);
      issue(csb_pkg::CSB_COMPARE_WITH_CONSTANT, 0, 7'h00, exp_pc + 10'h001);
      chk(16'(flags[2:0]), i ? 16'h0005 : 16'h0002);
    end
    $display("compare test done");
  endtask : t_compare
  initial begin
    rst = 1'h1;
    instr_valid = 1'h0;
    instr_op = csb_pkg::CSB_NOP;
    bit_index = 3'h0;
    branch_offset = 7'h00;
    constant_value = 8'h00;
    flags_load = 1'h0;
    flags_in = 8'h00;
    reg_sel = 1'h0;
    exp_pc = 10'h000;
    repeat (5) @(posedge clk_sys);
    rst <= 1'h0;
    @(negedge clk_sys);
    t_branches();
    t_skips();
    t_compare();
    test_done();
  end
endmodule : csb_unit_tb

// ==== logic/csb_alu_cmp.sv ====
// subtract-compare of a register against a constant, flags only
`timescale 1ns/10ps
module csb_alu_cmp (
  input wire logic [7:0] reg_value,
  input wire logic [7:0] constant_value,
  output logic [5:0] flags_out
);
  logic [7:0] diff;
  logic n_bit;
  logic v_bit;
  // result is discarded, only flags leave
  always_comb begin
    diff = reg_value - constant_value;
    n_bit = diff[7];
    v_bit = (reg_value[7] & ~constant_value[7] & ~diff[7]) |
            (~reg_value[7] & constant_value[7] & diff[7]);
    flags_out = '0;
    flags_out[csb_pkg::FLAG_C] = (~reg_value[7] & constant_value[7]) |
        (constant_value[7] & diff[7]) | (diff[7] & ~reg_value[7]);
    flags_out[csb_pkg::FLAG_Z] = (diff == 8'h00);
    flags_out[csb_pkg::FLAG_N] = n_bit;
    flags_out[csb_pkg::FLAG_V] = v_bit;
    flags_out[csb_pkg::FLAG_S] = n_bit ^ v_bit;
    flags_out[csb_pkg::FLAG_H] = (~reg_value[3] & constant_value[3]) |
        (constant_value[3] & diff[3]) | (diff[3] & ~reg_value[3]);
  end
endmodule : csb_alu_cmp

// ==== logic/csb_cond.sv ====
// branch and skip condition evaluation
`timescale 1ns/10ps
module csb_cond (
  input wire csb_pkg::csb_op_t op,
  input wire logic [7:0] flags,
  input wire logic [2:0] bit_index,
  input wire logic [7:0] gp_reg_value,
  input wire logic [7:0] io_reg_value,
  output logic cond_true
);
  // picks the tested bit and its required polarity
  always_comb begin
    case (op)
      csb_pkg::CSB_SKIP_IF_REG_BIT_CLEAR: cond_true = ~gp_reg_value[bit_index]; // [RULE2]
      csb_pkg::CSB_SKIP_IF_REG_BIT_SET: cond_true = gp_reg_value[bit_index]; // [RULE3]
      csb_pkg::CSB_SKIP_IF_IO_BIT_CLEAR: cond_true = ~io_reg_value[bit_index]; // [RULE4]
      csb_pkg::CSB_SKIP_IF_IO_BIT_SET: cond_true = io_reg_value[bit_index]; // [RULE5]
      csb_pkg::CSB_BRANCH_ON_STATUS_BIT_SET: cond_true = flags[bit_index]; // [RULE7]
      csb_pkg::CSB_BRANCH_ON_STATUS_BIT_CLEAR: cond_true = ~flags[bit_index]; // [RULE8]
      csb_pkg::CSB_BRANCH_IF_EQUAL: cond_true = flags[csb_pkg::FLAG_Z]; // [RULE10]
      csb_pkg::CSB_BRANCH_IF_NOT_EQUAL: cond_true = ~flags[csb_pkg::FLAG_Z]; // [RULE10]
      csb_pkg::CSB_BRANCH_IF_CARRY_SET,
      csb_pkg::CSB_BRANCH_IF_LOWER: cond_true = flags[csb_pkg::FLAG_C]; // [RULE11]
      csb_pkg::CSB_BRANCH_IF_CARRY_CLEAR,
      csb_pkg::CSB_BRANCH_IF_SAME_OR_HIGHER: cond_true = ~flags[csb_pkg::FLAG_C]; // [RULE11]
      csb_pkg::CSB_BRANCH_IF_MINUS: cond_true = flags[csb_pkg::FLAG_N]; // [RULE12]
      csb_pkg::CSB_BRANCH_IF_PLUS: cond_true = ~flags[csb_pkg::FLAG_N]; // [RULE12]
      csb_pkg::CSB_BRANCH_IF_SIGNED_GE:
        cond_true = ~(flags[csb_pkg::FLAG_N] ^ flags[csb_pkg::FLAG_V]); // [RULE13]
      csb_pkg::CSB_BRANCH_IF_SIGNED_LT:
        cond_true = flags[csb_pkg::FLAG_N] ^ flags[csb_pkg::FLAG_V]; // [RULE13]
      csb_pkg::CSB_BRANCH_IF_HALF_CARRY_SET: cond_true = flags[csb_pkg::FLAG_H]; // [RULE14]
      default: cond_true = 1'b0;
    endcase
  end
endmodule : csb_cond

// ==== logic/csb_pkg.sv ====
// shared constants and types for the compare, skip and branch unit
package csb_pkg;
  localparam int PC_W = 10;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  // skip distances and branch increment
  localparam logic [PC_W-1:0] STEP_ONE = 10'h001;
  localparam logic [PC_W-1:0] SKIP_SHORT = 10'h002;
  localparam logic [PC_W-1:0] SKIP_LONG = 10'h003;
  localparam logic [1:0] CYC_NONE = 2'h0;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  // operations decoded by the fetch side
  typedef enum logic [4:0] {
    CSB_NOP,
    CSB_COMPARE_WITH_CONSTANT,
    CSB_SKIP_IF_REG_BIT_CLEAR,
    CSB_SKIP_IF_REG_BIT_SET,
    CSB_SKIP_IF_IO_BIT_CLEAR,
    CSB_SKIP_IF_IO_BIT_SET,
    CSB_BRANCH_ON_STATUS_BIT_SET,
    CSB_BRANCH_ON_STATUS_BIT_CLEAR,
    CSB_BRANCH_IF_EQUAL,
    CSB_BRANCH_IF_NOT_EQUAL,
    CSB_BRANCH_IF_CARRY_SET,
    CSB_BRANCH_IF_CARRY_CLEAR,
    CSB_BRANCH_IF_SAME_OR_HIGHER,
    CSB_BRANCH_IF_LOWER,
    CSB_BRANCH_IF_MINUS,
    CSB_BRANCH_IF_PLUS,
    CSB_BRANCH_IF_SIGNED_GE,
    CSB_BRANCH_IF_SIGNED_LT,
    CSB_BRANCH_IF_HALF_CARRY_SET
  } csb_op_t;
  typedef enum {CSB_IDLE, CSB_WAIT} csb_state_t;
endpackage : csb_pkg

// ==== logic/csb_unit.sv ====
// program flow unit: compare with constant, skips and conditional branches
`timescale 1ns/10ps
// Function
// RULE1: compare-with-constant subtracts the constant from the register, sets Z N V C H, keeps the register, 1 cycle.
// RULE2: skip-if-register-bit-clear skips the next instruction (PC + 2 or 3) when the bit is 0, taking 1 to 3 cycles.
// RULE3: skip-if-register-bit-set skips the next instruction (PC + 2 or 3) when the bit is 1.
// RULE4: skip-if-I/O-bit-clear skips the next instruction when the I/O bit is 0, taking 1 to 3 cycles.
// RULE5: skip-if-I/O-bit-set skips the next instruction (PC + 2 or 3) when the I/O bit is 1.
// RULE6: skips and branches never change any status flag.
// RULE7: branch-on-status-bit-set branches to PC + offset + 1 when the indexed status bit is 1.
// RULE8: branch-on-status-bit-clear branches when the indexed status bit is 0, else falls through.
// RULE9: a taken branch loads PC + offset + 1 and takes 2 cycles, an untaken one takes 1.
// RULE10: branch-if-equal needs zero set, branch-if-not-equal needs zero clear.
// RULE11: carry-set and lower need carry set, carry-clear and same-or-higher need carry clear.
// RULE12: branch-if-minus needs negative set, branch-if-plus needs negative clear.
// RULE13: signed greater-or-equal needs N xor V = 0, signed less-than needs N xor V = 1.
// RULE14: branch-if-half-carry-set branches only when half-carry is 1.
// RULE15: the branch offset is signed two's complement, so targets may lie behind or ahead.
// RULE16: skipping a one-word instruction advances by 2, a two-word one by 3, one cycle per word.
module csb_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire csb_pkg::csb_op_t instr_op,
  input wire logic [2:0] bit_index,
  input wire logic [6:0] branch_offset,
  input wire logic [7:0] constant_value,
  input wire logic [7:0] gp_reg_value,
  input wire logic [7:0] io_reg_value,
  input wire logic next_is_two_word,
  input wire logic flags_load,
  input wire logic [7:0] flags_in,
  output logic instr_ready,
  output logic [csb_pkg::PC_W-1:0] pc,
  output logic [7:0] core_status_flags,
  output logic retire
);
  csb_pkg::csb_state_t state_reg;
  logic [1:0] wait_reg;
  logic [1:0] wait_next;
  logic [csb_pkg::PC_W-1:0] pc_next;
  logic [csb_pkg::PC_W-1:0] offset_ext;
  logic [5:0] cmp_flags;
  logic cond_true;
  logic is_skip;
  logic is_branch;
  logic accept;

  // flag result of the compare
  csb_alu_cmp u_cmp (
    .reg_value(gp_reg_value),
    .constant_value(constant_value),
    .flags_out(cmp_flags)
  );

  // condition for the skip or branch
  csb_cond u_cond (
    .op(instr_op),
    .flags(core_status_flags),
    .bit_index(bit_index),
    .gp_reg_value(gp_reg_value),
    .io_reg_value(io_reg_value),
    .cond_true(cond_true)
  );

  // classifies the instruction
  function automatic logic op_is_skip(input csb_pkg::csb_op_t op);
    op_is_skip = (op == csb_pkg::CSB_SKIP_IF_REG_BIT_CLEAR) ||
                 (op == csb_pkg::CSB_SKIP_IF_REG_BIT_SET) ||
                 (op == csb_pkg::CSB_SKIP_IF_IO_BIT_CLEAR) ||
                 (op == csb_pkg::CSB_SKIP_IF_IO_BIT_SET);
  endfunction : op_is_skip

  function automatic logic op_is_branch(input csb_pkg::csb_op_t op);
    op_is_branch = (op >= csb_pkg::CSB_BRANCH_ON_STATUS_BIT_SET) &&
                   (op <= csb_pkg::CSB_BRANCH_IF_HALF_CARRY_SET);
  endfunction : op_is_branch

  // decode, sign extension and accept handshake
  assign is_skip = op_is_skip(instr_op);
  assign is_branch = op_is_branch(instr_op);
  assign offset_ext = {{(csb_pkg::PC_W-7){branch_offset[6]}}, branch_offset}; // [RULE15]
  assign instr_ready = (state_reg == csb_pkg::CSB_IDLE);
  assign accept = instr_valid && instr_ready;

  // next program counter and extra cycles
  always_comb begin
    pc_next = pc + csb_pkg::STEP_ONE;
    wait_next = csb_pkg::CYC_NONE;
    if (is_skip && cond_true) begin
      if (next_is_two_word) begin // [RULE16]
        pc_next = pc + csb_pkg::SKIP_LONG; // [RULE2] [RULE3] [RULE4] [RULE5]
        wait_next = csb_pkg::CYC_TWO;
      end else begin
        pc_next = pc + csb_pkg::SKIP_SHORT; // [RULE2] [RULE3] [RULE4] [RULE5]
        wait_next = csb_pkg::CYC_ONE;
      end
    end else if (is_branch && cond_true) begin
      pc_next = pc + offset_ext + csb_pkg::STEP_ONE; // [RULE7] [RULE9]
      wait_next = csb_pkg::CYC_ONE; // [RULE9]
    end
  end

  // program counter moves once per accepted instruction
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pc <= csb_pkg::PC_RESET;
    end else if (accept) begin
      pc <= pc_next;
    end
  end

  // cycle counting for skips and taken branches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= csb_pkg::CSB_IDLE;
      wait_reg <= 2'h0;
    end else begin
      case (state_reg)
        csb_pkg::CSB_IDLE: begin
          if (accept && (wait_next != csb_pkg::CYC_NONE)) begin
            state_reg <= csb_pkg::CSB_WAIT;
            wait_reg <= wait_next;
          end
        end
        csb_pkg::CSB_WAIT: begin
          if (wait_reg == csb_pkg::CYC_ONE) begin
            state_reg <= csb_pkg::CSB_IDLE;
          end
          wait_reg <= wait_reg - csb_pkg::CYC_ONE;
        end
        default: begin
          state_reg <= csb_pkg::CSB_IDLE;
        end
      endcase
    end
  end

  // status flags: the compare or flags_load writes them, skips and branches do not
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      core_status_flags <= csb_pkg::FLAGS_RESET;
    end else if (accept && instr_op == csb_pkg::CSB_COMPARE_WITH_CONSTANT) begin
      core_status_flags[5:0] <= cmp_flags; // [RULE1] [RULE6]
    end else if (flags_load) begin
      core_status_flags <= flags_in;
    end
  end

  // retire pulse when an instruction completes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      retire <= 1'b0;
    end else begin
      retire <= (accept && wait_next == csb_pkg::CYC_NONE) ||
                (state_reg == csb_pkg::CSB_WAIT && wait_reg == csb_pkg::CYC_ONE);
    end
  end
endmodule : csb_unit
